// >>> hdl/tpm_pkg.sv
// Constants for the link performance-monitor snapshot bank.
// Assumes a 20 MHz clock and a 32-bit APB register port.
// Overview of operation
// - All mapping registers of the link refresh together in one clock edge.
// - A zero-to-one write on the manual snapshot bit refreshes every mapping.
// - With the periodic enable set, the group refreshes once per second.
// - Ten-bit CRC-6 error count in ESF; low byte 00H, top two bits 01H.
// - Twelve-bit F-bit error count in SF, DM, SLC-96; low 02H, high 03H.
// - In ESF the same counter counts frame alignment bit errors.
// - Three-bit count of framing position changes, mapped at 04H.
// - Five-bit count of sync loss events in all formats, mapped at 05H.
// - Sixteen-bit PRBS checker bit error count; low 06H, high 07H.
// - Sixteen-bit line violation count, AMI or B8ZS; low 08H, high 09H.
// - Ten-bit DDS pattern error count in DM format; low byte at 0AH.
// - DDS counter top two bits sit in bits 5 and 4 of 0BH.
`default_nettype none

package tpm_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_CRC_LOW   = 6'h00;
   localparam logic [5:0] IDX_CRC_HIGH  = 6'h01;
   localparam logic [5:0] IDX_FRAME_LOW  = 6'h02;
   localparam logic [5:0] IDX_FRAME_HIGH = 6'h03;
   localparam logic [5:0] IDX_POSITION   = 6'h04;
   localparam logic [5:0] IDX_SYNC       = 6'h05;
   localparam logic [5:0] IDX_PRBS_LOW  = 6'h06;
   localparam logic [5:0] IDX_PRBS_HIGH = 6'h07;
   localparam logic [5:0] IDX_LINE_LOW   = 6'h08;
   localparam logic [5:0] IDX_LINE_HIGH  = 6'h09;
   localparam logic [5:0] IDX_DDS_LOW   = 6'h0a;
   localparam logic [5:0] IDX_DDS_HIGH  = 6'h0b;
   localparam logic [5:0] IDX_CONTROL   = 6'h0c;
   localparam logic [5:0] IDX_FORMAT    = 6'h0d;
   localparam logic [5:0] IDX_STATUS    = 6'h0e;
   localparam logic [5:0] IDX_MASK      = 6'h0f;
   // Field positions
   localparam int POS_PERIODIC   = 0;
   localparam int POS_MANUAL     = 1;
   localparam int POS_CRC_HIGH   = 4;
   localparam int POS_DDS_HIGH   = 4;
   localparam int POS_POSITION   = 2;
   localparam int POS_EV_SNAP    = 0;
   localparam int POS_EV_SAT     = 1;
   // Frame formats
   localparam logic [1:0] FMT_SF    = 2'h0;
   localparam logic [1:0] FMT_ESF   = 2'h1;
   localparam logic [1:0] FMT_DM    = 2'h2;
   localparam logic [1:0] FMT_SLC96 = 2'h3;
   // Reset values
   localparam logic [1:0] RESET_FORMAT = FMT_SF;
   localparam logic [1:0] RESET_MASK   = 2'h0;
   // Timing
   localparam int SECOND_MS     = 1000;
   localparam int CLOCK_KHZ     = 20000;
   localparam int SECOND_CYCLES = CLOCK_KHZ * SECOND_MS;
   localparam int SECOND_WIDTH  = 32;
endpackage : tpm_pkg

`default_nettype wire

// >>> hdl/tpm_perf_monitor.sv
// Performance-monitor counter bank with grouped snapshot registers.
// Assumes event pulses come from framer logic on the same clock.
//
// The APB interface to the registers is this design's own decision.
`default_nettype none

module tpm_perf_monitor #(
   parameter int SECOND_CYCLES = tpm_pkg::SECOND_CYCLES
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Framer event pulses
   input  wire logic        crc_error,
   input  wire logic        frame_bit_error,
   input  wire logic        frame_position_change,
   input  wire logic        sync_loss,
   input  wire logic        prbs_bit_error,
   input  wire logic        line_violation,
   input  wire logic        dds_pattern_error,
   // Interrupt
   output var  logic        interrupt
);

   typedef struct packed {
      // Live counters
      logic [9:0]  crc_count;
      logic [11:0] frame_count;
      logic [2:0]  position_count;
      logic [4:0]  sync_count;
      logic [15:0] prbs_count;
      logic [15:0] line_count;
      logic [9:0]  dds_count;

      // Mapping registers
      logic [9:0]  crc_map;
      logic [11:0] frame_map;
      logic [2:0]  position_map;
      logic [4:0]  sync_map;
      logic [15:0] prbs_map;
      logic [15:0] line_map;
      logic [9:0]  dds_map;

      // Control and status
      logic        manual_snapshot_request;
      logic        previous_manual;
      logic        periodic_snapshot_enable;
      logic [1:0]  frame_format;
      logic [tpm_pkg::SECOND_WIDTH-1:0] second_count;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic        interrupt;

      // Bus answer
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } tpm_state_type;

   tpm_state_type state;
   tpm_state_type next_state;

   localparam logic [tpm_pkg::SECOND_WIDTH-1:0] SECOND_LAST =
      tpm_pkg::SECOND_WIDTH'(SECOND_CYCLES - 1);

   // Saturation values of the counters
   localparam logic [15:0] CRC_LIMIT      = 16'h03ff;
   localparam logic [15:0] FRAME_LIMIT    = 16'h0fff;
   localparam logic [15:0] POSITION_LIMIT = 16'h0007;
   localparam logic [15:0] SYNC_LIMIT     = 16'h001f;
   localparam logic [15:0] PRBS_LIMIT     = 16'hffff;
   localparam logic [15:0] LINE_LIMIT     = 16'hffff;
   localparam logic [15:0] DDS_LIMIT      = 16'h03ff;

   // Saturating increment; a counter never wraps
   function automatic logic [15:0] tpm_sat_inc(
      input logic [15:0] value,
      input logic [15:0] limit,
      input logic        event_in
   );
      logic [15:0] result;
      result = value;
      if (event_in && value != limit) begin
         result = value + 16'h0001;
      end
      return result;
   endfunction : tpm_sat_inc

   // Value an increment builds on; zero when the counter restarts
   function automatic logic [15:0] tpm_base(
      input logic [15:0] value,
      input logic        restart
   );
      logic [15:0] result;
      result = value;
      if (restart) begin
         result = 16'h0000;
      end
      return result;
   endfunction : tpm_base

   // An event that arrives while its counter holds its limit
   function automatic logic tpm_is_full(
      input logic [15:0] value,
      input logic [15:0] limit,
      input logic        event_in
   );
      logic result;
      result = event_in && value == limit;
      return result;
   endfunction : tpm_is_full

   // Frame format match for format-gated counters
   function automatic logic tpm_format_is(
      input logic [1:0] format,
      input logic [1:0] wanted
   );
      logic result;
      result = format == wanted;
      return result;
   endfunction : tpm_format_is

   logic       access;
   logic       write_hit;
   logic [5:0] index;
   logic       unmapped;
   logic       manual_edge;
   logic       second_tick;
   logic       snapshot;
   logic       crc_event;
   logic       frame_event;
   logic [6:0] full_hits;
   logic       dds_event;
   logic       saturated;
   logic [1:0] events;
   logic [1:0] clear_bits;
   logic [31:0] read_value;

   always_comb begin
      next_state = state;

      // Bus decode
      access     = psel && penable;
      index      = paddr[7:2];
      unmapped   = paddr[1:0] != 2'h0 || index > tpm_pkg::IDX_MASK;
      write_hit  = access && state.pready && pwrite;
      clear_bits = 2'h0;

      // Snapshot triggers
      manual_edge = state.manual_snapshot_request
                    && !state.previous_manual;
      next_state.previous_manual = state.manual_snapshot_request;
      second_tick = 1'b0;
      if (!state.periodic_snapshot_enable) begin
         next_state.second_count = '0;
      end else if (state.second_count == SECOND_LAST) begin
         next_state.second_count = '0;
         second_tick = 1'b1;
      end else begin
         next_state.second_count = state.second_count
            + tpm_pkg::SECOND_WIDTH'(1);
      end
      snapshot = manual_edge || second_tick;

      // Format gating of the counted events
      crc_event   = crc_error
                    && tpm_format_is(state.frame_format,
                                     tpm_pkg::FMT_ESF);
      frame_event = frame_bit_error;
      dds_event   = dds_pattern_error
                    && tpm_format_is(state.frame_format,
                                     tpm_pkg::FMT_DM);

      // Group copy into the mappings
      if (snapshot) begin
         next_state.crc_map      = state.crc_count;
         next_state.frame_map    = state.frame_count;
         next_state.position_map = state.position_count;
         next_state.sync_map     = state.sync_count;
         next_state.prbs_map     = state.prbs_count;
         next_state.line_map     = state.line_count;
         next_state.dds_map      = state.dds_count;
      end

      // Counters restart on a snapshot and count the same cycle's event
      // CRC-6 errors
      next_state.crc_count = 10'(tpm_sat_inc(
         tpm_base(16'(state.crc_count), snapshot),
         CRC_LIMIT,
         crc_event));
      full_hits[0] = tpm_is_full(
         16'(state.crc_count), CRC_LIMIT, crc_event);

      // Framing bit errors
      next_state.frame_count = 12'(tpm_sat_inc(
         tpm_base(16'(state.frame_count), snapshot),
         FRAME_LIMIT,
         frame_event));
      full_hits[1] = tpm_is_full(
         16'(state.frame_count), FRAME_LIMIT, frame_event);

      // Framing position changes
      next_state.position_count = 3'(tpm_sat_inc(
         tpm_base(16'(state.position_count), snapshot),
         POSITION_LIMIT,
         frame_position_change));
      full_hits[2] = tpm_is_full(
         16'(state.position_count), POSITION_LIMIT,
         frame_position_change);

      // Sync loss events
      next_state.sync_count = 5'(tpm_sat_inc(
         tpm_base(16'(state.sync_count), snapshot),
         SYNC_LIMIT,
         sync_loss));
      full_hits[3] = tpm_is_full(
         16'(state.sync_count), SYNC_LIMIT, sync_loss);

      // PRBS checker bit errors
      next_state.prbs_count = tpm_sat_inc(
         tpm_base(state.prbs_count, snapshot),
         PRBS_LIMIT,
         prbs_bit_error);
      full_hits[4] = tpm_is_full(
         state.prbs_count, PRBS_LIMIT, prbs_bit_error);

      // Line violations
      next_state.line_count = tpm_sat_inc(
         tpm_base(state.line_count, snapshot),
         LINE_LIMIT,
         line_violation);
      full_hits[5] = tpm_is_full(
         state.line_count, LINE_LIMIT, line_violation);

      // DDS pattern errors
      next_state.dds_count = 10'(tpm_sat_inc(
         tpm_base(16'(state.dds_count), snapshot),
         DDS_LIMIT,
         dds_event));
      full_hits[6] = tpm_is_full(
         16'(state.dds_count), DDS_LIMIT, dds_event);

      // An event that finds its counter full, outside a snapshot
      saturated = !snapshot && |full_hits;
      events = 2'h0;
      events[tpm_pkg::POS_EV_SNAP] = snapshot;
      events[tpm_pkg::POS_EV_SAT]  = saturated;

      // Register writes take effect at the edge where pready is high
      if (write_hit) begin
         case (index)
            tpm_pkg::IDX_CONTROL: begin
               next_state.periodic_snapshot_enable =
                  pwdata[tpm_pkg::POS_PERIODIC];
               next_state.manual_snapshot_request =
                  pwdata[tpm_pkg::POS_MANUAL];
            end
            tpm_pkg::IDX_FORMAT: begin
               next_state.frame_format = pwdata[1:0];
            end
            tpm_pkg::IDX_STATUS: begin
               clear_bits = pwdata[1:0];
            end
            tpm_pkg::IDX_MASK: begin
               next_state.mask = pwdata[1:0];
            end
            default: begin
               next_state.mask = state.mask;
            end
         endcase
      end

      // Sticky status, set wins over clear
      next_state.status = (state.status & ~clear_bits) | events;
      next_state.interrupt = |(next_state.status & next_state.mask);

      // Read mux over the mapping registers and own registers
      read_value = 32'h0000_0000;
      case (index)
         tpm_pkg::IDX_CRC_LOW: begin
            read_value[7:0] = state.crc_map[7:0];
         end
         tpm_pkg::IDX_CRC_HIGH: begin
            read_value[tpm_pkg::POS_CRC_HIGH +: 2] =
               state.crc_map[9:8];
         end
         tpm_pkg::IDX_FRAME_LOW: begin
            read_value[7:0] = state.frame_map[7:0];
         end
         tpm_pkg::IDX_FRAME_HIGH: begin
            read_value[3:0] = state.frame_map[11:8];
         end
         tpm_pkg::IDX_POSITION: begin
            read_value[tpm_pkg::POS_POSITION +: 3] =
               state.position_map;
         end
         tpm_pkg::IDX_SYNC: begin
            read_value[4:0] = state.sync_map;
         end
         tpm_pkg::IDX_PRBS_LOW: begin
            read_value[7:0] = state.prbs_map[7:0];
         end
         tpm_pkg::IDX_PRBS_HIGH: begin
            read_value[7:0] = state.prbs_map[15:8];
         end
         tpm_pkg::IDX_LINE_LOW: begin
            read_value[7:0] = state.line_map[7:0];
         end
         tpm_pkg::IDX_LINE_HIGH: begin
            read_value[7:0] = state.line_map[15:8];
         end
         tpm_pkg::IDX_DDS_LOW: begin
            read_value[7:0] = state.dds_map[7:0];
         end
         tpm_pkg::IDX_DDS_HIGH: begin
            read_value[tpm_pkg::POS_DDS_HIGH +: 2] =
               state.dds_map[9:8];
         end
         tpm_pkg::IDX_CONTROL: begin
            read_value[tpm_pkg::POS_PERIODIC] =
               state.periodic_snapshot_enable;
            read_value[tpm_pkg::POS_MANUAL] =
               state.manual_snapshot_request;
         end
         tpm_pkg::IDX_FORMAT: begin
            read_value[1:0] = state.frame_format;
         end
         tpm_pkg::IDX_STATUS: begin
            read_value[1:0] = state.status;
         end
         tpm_pkg::IDX_MASK: begin
            read_value[1:0] = state.mask;
         end
         default: begin
            read_value = 32'h0000_0000;
         end
      endcase
      if (unmapped) begin
         read_value = 32'h0000_0000;
      end

      // APB answer one cycle into the access phase
      next_state.pready  = 1'b0;
      next_state.pslverr = 1'b0;
      if (access && !state.pready) begin
         next_state.pready  = 1'b1;
         next_state.pslverr = unmapped;
         if (!pwrite) begin
            next_state.prdata = read_value;
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state <= '0;
         state.frame_format <= tpm_pkg::RESET_FORMAT;
         state.mask <= tpm_pkg::RESET_MASK;
      end else begin
         state <= next_state;
      end
   end

   assign prdata    = state.prdata;
   assign pready    = state.pready;
   assign pslverr   = state.pslverr;
   assign interrupt = state.interrupt;

endmodule : tpm_perf_monitor

`default_nettype wire

// >>> tb/tpm_perf_monitor_props.sv
// Port checker for the monitor bank: APB timing and field layout.
// Assumes it is bound into tpm_perf_monitor.
`default_nettype none

module tpm_perf_monitor_props #(
   parameter int SECOND_CYCLES = 50
) (
   // Clock and reset
   input wire logic        clock,
   input wire logic        reset,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   wire [5:0] idx = paddr[7:2];
   wire       rd_ok = pready && !pwrite && !pslverr;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready high two cycles");
   a_ready_wait: assert property (psel && $rose(penable) |=> pready)
      else $error("pready late");
   a_err_decode: assert property (pready |->
      pslverr == (idx > 6'h0f || paddr[1:0] != 2'h0))
      else $error("pslverr decode wrong");
   a_crc_high: assert property (rd_ok && idx == tpm_pkg::IDX_CRC_HIGH
      |-> prdata[31:6] == 0 && prdata[3:0] == 0)
      else $error("crc high field wrong");
   a_frame_high: assert property (rd_ok && idx == tpm_pkg::IDX_FRAME_HIGH
      |-> prdata[31:4] == 0)
      else $error("framing high field wrong");
   a_position_field: assert property (rd_ok && idx == tpm_pkg::IDX_POSITION
      |-> prdata[31:5] == 0 && prdata[1:0] == 0)
      else $error("position field wrong");
   a_sync_field: assert property (rd_ok && idx == tpm_pkg::IDX_SYNC
      |-> prdata[31:5] == 0)
      else $error("sync field wrong");
   a_dds_high: assert property (rd_ok && idx == tpm_pkg::IDX_DDS_HIGH
      |-> prdata[31:6] == 0 && prdata[3:0] == 0)
      else $error("dds high field wrong");
   a_prdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
      else $error("prdata moved outside a read");
   c_dds_read: cover property (rd_ok && idx == tpm_pkg::IDX_DDS_HIGH);
   c_err: cover property (pready && pslverr);
   c_write: cover property (pready && pwrite);
endmodule : tpm_perf_monitor_props

`default_nettype wire

// >>> tb/tb_tpm_perf_monitor.sv
// Self-checking bench for the monitor bank.
// Assumes the design package and tpm_perf_monitor are compiled first.
`default_nettype none

module tb_tpm_perf_monitor;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      int         ev;
      int         n;
      logic [1:0] fmt;
      logic [5:0] ia;
      logic [7:0] ea;
      logic [5:0] ib;
      logic [7:0] eb;
   } tpm_row_type;
   localparam int SEC = 50;
   localparam logic [5:0] CTL = tpm_pkg::IDX_CONTROL;
   localparam logic [5:0] STA = tpm_pkg::IDX_STATUS;
   localparam logic [5:0] MSK = tpm_pkg::IDX_MASK;
   logic        clock, reset, psel, penable, pwrite, pready, pslverr, e;
   logic        interrupt;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [6:0]  ev;
   int          fails = 0, n_checks = 0, cyc = 0;
   // Event bit, pulses, format, two reads with expected bytes
   tpm_row_type rows [10] = '{
      '{5, 3, 2'h0, 6'h08, 8'h03, 6'h09, 8'h00},
      '{4, 257, 2'h0, 6'h06, 8'h01, 6'h07, 8'h01},
      '{0, 5, 2'h1, 6'h00, 8'h05, 6'h01, 8'h00},
      '{0, 5, 2'h0, 6'h00, 8'h00, 6'h01, 8'h00},
      '{1, 258, 2'h2, 6'h02, 8'h02, 6'h03, 8'h01},
      '{1, 4, 2'h1, 6'h02, 8'h04, 6'h03, 8'h00},
      '{2, 3, 2'h0, 6'h04, 8'h0c, 6'h04, 8'h0c},
      '{3, 7, 2'h3, 6'h05, 8'h07, 6'h05, 8'h07},
      '{6, 257, 2'h2, 6'h0a, 8'h01, 6'h0b, 8'h10},
      '{6, 2, 2'h1, 6'h0a, 8'h00, 6'h0b, 8'h00}};

   tpm_perf_monitor #(.SECOND_CYCLES(SEC)) i_dut (
      .clock(clock), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .crc_error(ev[0]),
      .frame_bit_error(ev[1]), .frame_position_change(ev[2]),
      .sync_loss(ev[3]), .prbs_bit_error(ev[4]), .line_violation(ev[5]),
      .dds_pattern_error(ev[6]), .interrupt(interrupt));

   task close_out;
      $display("checks=%0d errors=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   task chk32(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk32
   task chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk1
   task apb(input logic w, input logic [5:0] i, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {i, 2'h0};
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd(input logic [5:0] i, input logic [31:0] x);
      apb(1'b0, i, 32'h0);
      chk32(q, x);
      chk1(e, i > 6'h0f);
   endtask : rd
   task pulse(input int k, input int n);
      repeat (n) begin
         @(posedge clock);
         ev <= 7'h01 << k;
      end
      @(posedge clock);
      ev <= 7'h00;
   endtask : pulse
   task snap;
      apb(1'b1, CTL, 32'h2);
      apb(1'b1, CTL, 32'h0);
   endtask : snap
   task chk_int(input logic x);
      repeat (2) @(posedge clock);
      chk1(interrupt, x);
   endtask : chk_int

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, ev} = '0;
      reset = 1'b1;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      for (int i = 0; i < 17; i++) rd(i[5:0], 32'h0);
      foreach (rows[r]) begin
         apb(1'b1, tpm_pkg::IDX_FORMAT, {30'h0, rows[r].fmt});
         pulse(rows[r].ev, rows[r].n);
         snap();
         rd(rows[r].ia, {24'h0, rows[r].ea});
         rd(rows[r].ib, {24'h0, rows[r].eb});
      end
      apb(1'b1, STA, 32'h3);
      pulse(2, 9);
      chk_int(1'b0);
      apb(1'b1, MSK, 32'h2);
      chk_int(1'b1);
      apb(1'b1, STA, 32'h2);
      chk_int(1'b0);
      snap();
      rd(tpm_pkg::IDX_POSITION, 32'h1c);
      pulse(2, 1);
      rd(tpm_pkg::IDX_POSITION, 32'h1c);
      rd(STA, 32'h1);
      apb(1'b1, MSK, 32'h1);
      apb(1'b1, STA, 32'h3);
      apb(1'b1, CTL, 32'h1);
      pulse(5, 2);
      repeat (SEC + 10) @(posedge clock);
      rd(tpm_pkg::IDX_LINE_LOW, 32'h2);
      chk1(interrupt, 1'b1);
      pulse(5, 1);
      repeat (SEC) @(posedge clock);
      rd(tpm_pkg::IDX_LINE_LOW, 32'h1);
      apb(1'b1, CTL, 32'h0);
      apb(1'b1, tpm_pkg::IDX_LINE_LOW, 32'hff);
      rd(tpm_pkg::IDX_LINE_LOW, 32'h1);
      // Mid-run reset clears mappings, control and interrupt
      reset <= 1'b1;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      rd(tpm_pkg::IDX_LINE_LOW, 32'h0);
      rd(CTL, 32'h0);
      chk1(interrupt, 1'b0);
      close_out();
   end
endmodule : tb_tpm_perf_monitor

bind tpm_perf_monitor tpm_perf_monitor_props #(
   .SECOND_CYCLES(SECOND_CYCLES)) i_props (
   .clock(clock), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));

`default_nettype wire
